// ### hw/agu_pkg.sv
package agu_pkg;

  // ==========================================================================
  // control word layout
  localparam int CTRL_X_EN_BIT = 15;
  localparam int CTRL_Y_EN_BIT = 14;
  localparam int X_SEL_LSB = 0;
  localparam int Y_SEL_LSB = 4;
  localparam logic [3:0] SEL_OFF = 4'hF;

  // ==========================================================================
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] START_RESET = 16'h0000;
  localparam logic [15:0] END_RESET = 16'h0001;
  localparam logic [15:0] WORK_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0800;

  // ==========================================================================
  // register indices
  localparam logic [3:0] DEFAULT_WORKING_REG = 4'h0;
  localparam logic [3:0] X_PREFETCH_REG_A = 4'h8;
  localparam logic [3:0] X_PREFETCH_REG_B = 4'h9;
  localparam logic [3:0] Y_PREFETCH_REG_A = 4'hA;
  localparam logic [3:0] Y_PREFETCH_REG_B = 4'hB;
  localparam logic [3:0] STACK_POINTER_REG = 4'hF;

  // ==========================================================================
  // widths and allowed steps
  localparam int FILE_ADDR_W = 13;
  localparam logic [15:0] MAC_STEP_2 = 16'h0002;
  localparam logic [15:0] MAC_STEP_4 = 16'h0004;
  localparam logic [15:0] MAC_STEP_6 = 16'h0006;

  typedef enum logic [2:0] {
    CL_FILE = 3'b000,
    CL_MCU = 3'b001,
    CL_MOVE = 3'b010,
    CL_MAC = 3'b011,
    CL_BRANCH = 3'b100,
    CL_DISABLE = 3'b101
  } agu_class_e;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'b000,
    AM_IND = 3'b001,
    AM_POST = 3'b010,
    AM_PRE = 3'b011,
    AM_REGOFS = 3'b100,
    AM_LITOFS = 3'b101,
    AM_FILE = 3'b110
  } agu_mode_e;

  typedef enum logic [2:0] {
    CR_CTRL = 3'b000,
    CR_X_START = 3'b001,
    CR_X_END = 3'b010,
    CR_Y_START = 3'b011,
    CR_Y_END = 3'b100
  } agu_creg_e;

  typedef struct packed {
    agu_class_e iclass;
    agu_mode_e mode;
    logic [3:0] ptr;
    logic [15:0] modifier;
    logic [3:0] ofs_reg;
    logic y_en;
    agu_mode_e y_mode;
    logic [3:0] y_ptr;
    logic [15:0] y_modifier;
    logic [15:0] literal;
    logic lit_wide;
    logic [FILE_ADDR_W-1:0] file_addr;
    logic to_work;
    logic prog;
  } agu_req_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic prog;
    logic [15:0] ea;
  } agu_ea_s;

  typedef struct packed {
    logic valid;
    logic to_work;
    logic [3:0] reg_idx;
    logic [15:0] addr;
  } agu_dest_s;

endpackage

// ### hw/agu_circ.sv
`timescale 1ns/10ps
module agu_circ
  import agu_pkg::*;
(
  // control
  input wire logic i_active,
  input wire logic i_dec,
  input wire logic i_word_only,
  // bounds
  input wire logic [15:0] i_start,
  input wire logic [15:0] i_end,
  // address
  input wire logic [15:0] i_addr,
  output logic [15:0] o_addr
);

  logic [15:0] len;
  logic pow2;
  logic over;
  logic under;
  logic [15:0] fixed;

  // ==========================================================================
  // boundary correction
  always_comb
  begin
    len = i_end - i_start + 16'h0001; // RL21
    pow2 = (len & (len - 16'h0001)) == 16'h0000; // RL18
    over = (i_addr > i_end) && (pow2 || !i_dec); // RL24 RL18
    under = (i_addr < i_start) && (pow2 || i_dec); // RL24 RL18
    fixed = i_addr;
    if (i_active && over)
    begin
      fixed = i_addr - len; // RL26
    end
    else if (i_active && under)
    begin
      fixed = i_addr + len; // RL26
    end
    o_addr = i_word_only ? {fixed[15:1], 1'b0} : fixed; // RL20
  end

endmodule

// ### hw/agu_top.sv
`timescale 1ns/10ps
// How it works
// RL1: two separate generators; Y one serves only word reads of multiply-accumulate class.
// RL2: linear and circular work for data and program space; no bit-reversal here.
// RL3: file register access uses 13-bit field, reaching lowest 8192 bytes.
// RL4: file result goes to same address or working register zero; move reaches all.
// RL5: three-operand first operand is a register read directly; second register/memory/literal.
// RL6: indirect uses pointer as address; post-modified uses pointer then steps it.
// RL7: pre-modified adds signed step first, then uses updated pointer.
// RL8: register offset adds second register; literal offset adds literal to pointer.
// RL9: move adds indexed and literal offset modes; literals 8/16 versus 5/10 bits.
// RL10: move source and destination modes differ; one offset register field shared.
// RL11: prefetch pointers 8,9 go to X generator, 10,11 to Y generator.
// RL12: software keeps prefetch addresses inside their own space before and after steps.
// RL13: indexed multiply-accumulate mode only through register 9 (X) and 11 (Y).
// RL14: multiply-accumulate allows indirect, indexed, and post-step of 2, 4 or 6.
// RL15: branch literal is 16-bit signed; interrupt-disable count is 14-bit unsigned.
// RL16: one circular buffer in X and one in Y; X also covers program space.
// RL17: software should avoid frame and stack pointers as circular pointers.
// RL18: buffers wrap one way; power-of-two length checks both bounds.
// RL19: each buffer has 16-bit start and end registers, X pair and Y pair.
// RL20: Y circular addresses are word addresses; bit zero always cleared.
// RL21: length is end minus start, never stored; at most 32K words. The code uses end minus start plus one.
// RL22: X circular on only with enable bit 15 and select field not 15.
// RL23: Y circular on only with enable bit 14 and select bits 7:4 not 15.
// RL24: bounds compare beyond, not equal, so jumps past a bound still wrap.
// RL25: corrected address written back only for pre/post; offsets leave pointer unchanged.
// RL26: incrementing past end wraps back by length; decrementing past start wraps forward.
module agu_top
  import agu_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // decoder request
  input wire logic i_req_valid,
  input wire agu_req_s i_req,
  // working register write and read
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_idx,
  input wire logic [15:0] i_wr_data,
  input wire logic [3:0] i_rd_idx,
  output logic [15:0] o_rd_data,
  // circular buffer registers
  input wire logic i_circ_wr_en,
  input wire agu_creg_e i_circ_wr_sel,
  input wire logic [15:0] i_circ_wr_data,
  output logic [15:0] o_circular_control,
  // generated addresses and operands
  output agu_ea_s o_x,
  output agu_ea_s o_y,
  output agu_dest_s o_dest,
  output logic [15:0] o_op1,
  output logic [15:0] o_literal
);

  logic [15:0] regs [16];
  logic [15:0] circular_control;
  logic [15:0] x_circ_start;
  logic [15:0] x_circ_end;
  logic [15:0] y_circ_start;
  logic [15:0] y_circ_end;

  logic [15:0] x_ptr_val;
  logic [15:0] y_ptr_val;
  logic [15:0] ofs_val;
  logic [15:0] x_raw;
  logic [15:0] y_raw;
  logic [15:0] x_corr;
  logic [15:0] y_corr;
  logic x_err;
  logic y_err;
  logic x_access;
  logic x_dec;
  logic y_dec;
  logic x_circ_on;
  logic y_circ_on;
  logic x_wb_en;
  logic y_wb_en;
  logic [15:0] next_x_ea;
  logic [15:0] next_y_ea;
  logic [15:0] next_literal;

  function automatic logic step_ok(input logic [15:0] m);
    logic [15:0] mag;
    mag = m[15] ? (16'h0000 - m) : m;
    return (mag == MAC_STEP_2) || (mag == MAC_STEP_4) || (mag == MAC_STEP_6);
  endfunction

  function automatic logic mac_mode_ok(input agu_mode_e md, input logic [15:0] m);
    return (md == AM_IND) || (md == AM_REGOFS) || ((md == AM_POST) && step_ok(m));
  endfunction

  // ==========================================================================
  // circular buffer registers
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      circular_control <= CTRL_RESET;
      x_circ_start <= START_RESET;
      x_circ_end <= END_RESET;
      y_circ_start <= START_RESET;
      y_circ_end <= END_RESET;
    end
    else if (i_ce && i_circ_wr_en)
    begin
      unique case (i_circ_wr_sel)
        CR_CTRL: circular_control <= i_circ_wr_data;
        CR_X_START: x_circ_start <= {i_circ_wr_data[15:1], 1'b0}; // RL19
        CR_X_END: x_circ_end <= {i_circ_wr_data[15:1], 1'b1}; // RL19
        CR_Y_START: y_circ_start <= {i_circ_wr_data[15:1], 1'b0}; // RL19
        CR_Y_END: y_circ_end <= {i_circ_wr_data[15:1], 1'b1}; // RL19
        default: circular_control <= circular_control;
      endcase
    end
  end

  assign o_circular_control = circular_control;

  // ==========================================================================
  // X generator
  always_comb
  begin
    x_ptr_val = regs[i_req.ptr];
    ofs_val = regs[i_req.ofs_reg]; // RL10
    x_dec = i_req.modifier[15];
    x_err = 1'b0;
    x_access = 1'b1;
    x_raw = x_ptr_val; // RL6
    unique case (i_req.mode)
      AM_DIRECT:
      begin
        x_access = 1'b0;
      end
      AM_IND, AM_POST:
      begin
        x_raw = (i_req.mode == AM_POST) ? x_ptr_val + i_req.modifier : x_ptr_val; // RL6
      end
      AM_PRE:
      begin
        x_raw = x_ptr_val + i_req.modifier; // RL7
      end
      AM_REGOFS:
      begin
        x_raw = x_ptr_val + ofs_val; // RL8
        x_dec = ofs_val[15];
      end
      AM_LITOFS:
      begin
        x_raw = x_ptr_val + i_req.modifier; // RL8
      end
      AM_FILE:
      begin
        if (i_req.iclass == CL_MOVE)
        begin
          x_raw = i_req.literal; // RL4
        end
        else
        begin
          x_raw = {{(16 - FILE_ADDR_W){1'b0}}, i_req.file_addr}; // RL3
        end
      end
      default:
      begin
        x_err = 1'b1;
      end
    endcase
    unique case (i_req.iclass)
      CL_FILE: x_err = x_err || (i_req.mode != AM_FILE); // RL3
      CL_MCU: x_err = x_err || (i_req.mode == AM_REGOFS) || (i_req.mode == AM_LITOFS)
        || (i_req.mode == AM_FILE); // RL9
      CL_MOVE: x_err = x_err; // RL9
      CL_MAC:
      begin
        x_err = x_err || ((i_req.ptr != X_PREFETCH_REG_A) && (i_req.ptr != X_PREFETCH_REG_B))
          || !mac_mode_ok(i_req.mode, i_req.modifier) // RL11 RL14
          || ((i_req.mode == AM_REGOFS) && (i_req.ptr != X_PREFETCH_REG_B)); // RL13
      end
      CL_BRANCH, CL_DISABLE: x_access = 1'b0;
      default: x_err = 1'b1;
    endcase
    x_circ_on = circular_control[CTRL_X_EN_BIT] // RL22
      && (circular_control[X_SEL_LSB +: 4] != SEL_OFF) // RL22
      && (circular_control[X_SEL_LSB +: 4] == i_req.ptr) // RL16 RL2
      && (i_req.mode != AM_FILE) && (i_req.mode != AM_DIRECT);
  end

  agu_circ u_x_circ (
    .i_active(x_circ_on),
    .i_dec(x_dec),
    .i_word_only(1'b0),
    .i_start(x_circ_start),
    .i_end(x_circ_end),
    .i_addr(x_raw),
    .o_addr(x_corr)
  );

  // post-modify reads the old pointer; others use the corrected sum
  assign next_x_ea = (i_req.mode == AM_POST) ? x_ptr_val : x_corr; // RL6 RL25
  assign x_wb_en = i_req_valid && x_access && !x_err
    && ((i_req.mode == AM_PRE) || (i_req.mode == AM_POST)); // RL25

  // ==========================================================================
  // Y generator, multiply-accumulate word reads only
  always_comb
  begin
    y_ptr_val = regs[i_req.y_ptr];
    y_dec = i_req.y_modifier[15];
    y_raw = y_ptr_val;
    if (i_req.y_mode == AM_POST)
    begin
      y_raw = y_ptr_val + i_req.y_modifier;
    end
    else if (i_req.y_mode == AM_REGOFS)
    begin
      y_raw = y_ptr_val + ofs_val;
      y_dec = ofs_val[15];
    end
    y_err = ((i_req.y_ptr != Y_PREFETCH_REG_A) && (i_req.y_ptr != Y_PREFETCH_REG_B)) // RL11
      || !mac_mode_ok(i_req.y_mode, i_req.y_modifier) // RL14
      || ((i_req.y_mode == AM_REGOFS) && (i_req.y_ptr != Y_PREFETCH_REG_B)); // RL13
    y_circ_on = circular_control[CTRL_Y_EN_BIT] // RL23
      && (circular_control[Y_SEL_LSB +: 4] != SEL_OFF) // RL23
      && (circular_control[Y_SEL_LSB +: 4] == i_req.y_ptr);
  end

  agu_circ u_y_circ (
    .i_active(y_circ_on),
    .i_dec(y_dec),
    .i_word_only(1'b1),
    .i_start(y_circ_start),
    .i_end(y_circ_end),
    .i_addr(y_raw),
    .o_addr(y_corr)
  );

  assign next_y_ea = (i_req.y_mode == AM_POST) ? {y_ptr_val[15:1], 1'b0} : y_corr; // RL20
  assign y_wb_en = i_req_valid && (i_req.iclass == CL_MAC) && i_req.y_en && !y_err // RL1
    && (i_req.y_mode == AM_POST); // RL25

  // ==========================================================================
  // working registers with pointer write-back
  generate
    for (genvar gi = 0; gi < 16; gi++)
    begin : g_regs
      always_ff @(posedge i_core_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          regs[gi] <= (gi == 15) ? SP_RESET : WORK_RESET;
        end
        else if (i_ce)
        begin
          if (x_wb_en && (i_req.ptr == 4'(gi)))
          begin
            regs[gi] <= x_corr; // RL25 RL7
          end
          else if (y_wb_en && (i_req.y_ptr == 4'(gi)))
          begin
            regs[gi] <= y_corr; // RL25
          end
          else if (i_wr_en && (i_wr_idx == 4'(gi)))
          begin
            regs[gi] <= i_wr_data;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // literal extraction
  always_comb
  begin
    unique case (i_req.iclass)
      CL_MCU: next_literal = i_req.lit_wide ? {6'h00, i_req.literal[9:0]}
        : {11'h000, i_req.literal[4:0]}; // RL5 RL9
      CL_MOVE: next_literal = i_req.lit_wide ? i_req.literal
        : {8'h00, i_req.literal[7:0]}; // RL9
      CL_BRANCH: next_literal = i_req.literal; // RL15
      CL_DISABLE: next_literal = {2'b00, i_req.literal[13:0]}; // RL15
      default: next_literal = 16'h0000;
    endcase
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_x <= '0;
      o_y <= '0;
      o_dest <= '0;
      o_op1 <= 16'h0000;
      o_literal <= 16'h0000;
      o_rd_data <= 16'h0000;
    end
    else if (i_ce)
    begin
      o_rd_data <= regs[i_rd_idx];
      o_op1 <= ofs_val; // RL5
      o_literal <= next_literal;
      o_x.valid <= i_req_valid && x_access && !x_err;
      o_x.err <= i_req_valid && x_err;
      o_x.prog <= i_req.prog; // RL2 RL16
      o_x.ea <= next_x_ea;
      o_y.valid <= i_req_valid && (i_req.iclass == CL_MAC) && i_req.y_en && !y_err; // RL1
      o_y.err <= i_req_valid && (i_req.iclass == CL_MAC) && i_req.y_en && y_err;
      o_y.prog <= 1'b0;
      o_y.ea <= next_y_ea; // RL20
      o_dest.valid <= i_req_valid && (i_req.iclass == CL_FILE) && !x_err;
      o_dest.to_work <= i_req.to_work; // RL4
      o_dest.reg_idx <= DEFAULT_WORKING_REG; // RL4
      o_dest.addr <= next_x_ea; // RL4
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_pre_req;
    i_ce && i_req_valid && (i_req.mode == AM_PRE) && !x_err && x_access && !i_circ_wr_en;
  endsequence

  sequence s_regofs_req;
    i_ce && i_req_valid && (i_req.mode == AM_REGOFS) && !x_err && !i_wr_en;
  endsequence

  a_pre_writeback: assert property (s_pre_req ##1 1'b1 |-> regs[$past(i_req.ptr)] == o_x.ea) // RL7
    else $error("pre-modified pointer differs from issued address");

  a_regofs_keep_ptr: assert property (s_regofs_req ##1 1'b1 |->
    regs[$past(i_req.ptr)] == $past(x_ptr_val)) // RL25
    else $error("register-offset access changed its pointer");

  a_post_ea_old: assert property (i_ce && i_req_valid && (i_req.mode == AM_POST) && !x_err
    |=> o_x.ea == $past(x_ptr_val)) // RL6
    else $error("post-modified access did not use old pointer");

  a_y_word_addr: assert property (o_y.valid |-> o_y.ea[0] == 1'b0) // RL20
    else $error("Y address is not word aligned");

  a_mac_x_route: assert property (i_ce && i_req_valid && (i_req.iclass == CL_MAC)
    && (i_req.ptr != X_PREFETCH_REG_A) && (i_req.ptr != X_PREFETCH_REG_B) |=> o_x.err) // RL11
    else $error("bad X prefetch register accepted");

  a_mac_step_set: assert property (i_ce && i_req_valid && (i_req.iclass == CL_MAC)
    && (i_req.mode == AM_POST) && !step_ok(i_req.modifier) |=> !o_x.valid) // RL14
    else $error("illegal multiply-accumulate step accepted");

  a_file_direct: assert property (i_ce && i_req_valid && (i_req.iclass == CL_FILE)
    && (i_req.mode == AM_FILE) |=> o_x.valid && (o_x.ea[15:FILE_ADDR_W] == '0)
    && (o_x.ea[FILE_ADDR_W-1:0] == $past(i_req.file_addr))) // RL3
    else $error("file register address wrong");

  a_disable_count: assert property (i_ce && i_req_valid && (i_req.iclass == CL_DISABLE)
    |=> o_literal[15:14] == 2'b00) // RL15
    else $error("disable count wider than 14 bits");

  a_x_circ_off: assert property (i_ce && i_req_valid && (i_req.mode == AM_PRE) && !x_err
    && (!circular_control[CTRL_X_EN_BIT] || (circular_control[X_SEL_LSB +: 4] == SEL_OFF))
    |=> o_x.ea == $past(x_raw)) // RL22
    else $error("X correction applied while disabled");

endmodule

// ### bench/agu_dec_model.sv
`timescale 1ns/10ps
// ============================================================
// decoder side: one request per call, held for one rising clock edge
module agu_dec_model
  import agu_pkg::*;
(
  // clock
  input wire logic i_core_clk,
  // request to the generators
  output logic o_req_valid,
  output agu_req_s o_req
);
  initial
  begin
    o_req_valid = 1'b0;
    o_req = '0;
  end

  // callers keep prefetch pointers inside their own space and never make
  // the frame or stack pointer circular
  task automatic issue(input agu_req_s r);
    o_req = r;
    o_req_valid = 1'b1;
    @(negedge i_core_clk);
    o_req_valid = 1'b0;
  endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/10ps
// ============================================================
// bench top
module tb
  import agu_pkg::*;
;
  typedef struct packed {
    agu_class_e c;
    agu_mode_e m;
    logic [3:0] p;
    logic [15:0] mod;
    logic [15:0] base;
    logic v;
    logic e;
    logic [15:0] ea;
    logic [15:0] wb;
  } agu_row_s;

  logic i_core_clk, i_resetn, i_ce, i_wr_en, i_circ_wr_en, req_valid;
  logic [3:0] i_wr_idx, i_rd_idx;
  logic [15:0] i_wr_data, i_circ_wr_data, o_rd_data, o_circular_control, o_op1, o_literal;
  agu_creg_e i_circ_wr_sel;
  agu_req_s req, r;
  agu_ea_s o_x, o_y;
  agu_dest_s o_dest;
  int num_errors, checked;

  // class, mode, ptr, modifier, base, valid, err, ea, pointer after
  agu_row_s rows [12] = '{
    '{CL_MCU, AM_IND, 4'h1, 16'h0000, 16'h0010, 1'b1, 1'b0, 16'h0010, 16'h0010},
    '{CL_MCU, AM_POST, 4'h1, 16'h0002, 16'h0010, 1'b1, 1'b0, 16'h0010, 16'h0012},
    '{CL_MCU, AM_PRE, 4'h1, 16'hFFFE, 16'h0010, 1'b1, 1'b0, 16'h000E, 16'h000E},
    '{CL_MOVE, AM_REGOFS, 4'h1, 16'h0000, 16'h0010, 1'b1, 1'b0, 16'h0014, 16'h0010},
    '{CL_MOVE, AM_LITOFS, 4'h1, 16'h0006, 16'h0010, 1'b1, 1'b0, 16'h0016, 16'h0010},
    '{CL_MCU, AM_REGOFS, 4'h1, 16'h0000, 16'h0010, 1'b0, 1'b1, 16'h0000, 16'h0010},
    '{CL_MAC, AM_POST, 4'h8, 16'h0004, 16'h0010, 1'b1, 1'b0, 16'h0010, 16'h0014},
    '{CL_MAC, AM_POST, 4'h9, 16'hFFFA, 16'h0010, 1'b1, 1'b0, 16'h0010, 16'h000A},
    '{CL_MAC, AM_POST, 4'h8, 16'h0008, 16'h0010, 1'b0, 1'b1, 16'h0000, 16'h0010},
    '{CL_MAC, AM_REGOFS, 4'h9, 16'h0000, 16'h0010, 1'b1, 1'b0, 16'h0014, 16'h0010},
    '{CL_MAC, AM_REGOFS, 4'h8, 16'h0000, 16'h0010, 1'b0, 1'b1, 16'h0000, 16'h0010},
    '{CL_MAC, AM_IND, 4'h1, 16'h0000, 16'h0010, 1'b0, 1'b1, 16'h0000, 16'h0010}
  };

  agu_top i_agu_top (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_req_valid(req_valid), .i_req(req),
    .i_wr_en(i_wr_en), .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data),
    .i_rd_idx(i_rd_idx), .o_rd_data(o_rd_data),
    .i_circ_wr_en(i_circ_wr_en), .i_circ_wr_sel(i_circ_wr_sel),
    .i_circ_wr_data(i_circ_wr_data), .o_circular_control(o_circular_control),
    .o_x(o_x), .o_y(o_y), .o_dest(o_dest), .o_op1(o_op1), .o_literal(o_literal)
  );

  agu_dec_model i_agu_dec_model (
    .i_core_clk(i_core_clk), .o_req_valid(req_valid), .o_req(req)
  );

  // ============================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chkb(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // write ports are left raised; the next request lowers them
  task automatic wput(input logic [3:0] idx, input logic [15:0] d);
    i_wr_en = 1'b1;
    i_wr_idx = idx;
    i_wr_data = d;
    @(negedge i_core_clk);
  endtask

  task automatic creg(input agu_creg_e sel, input logic [15:0] d);
    i_circ_wr_en = 1'b1;
    i_circ_wr_sel = sel;
    i_circ_wr_data = d;
    @(negedge i_core_clk);
  endtask

  task automatic send(input agu_req_s q);
    @(negedge i_core_clk);
    i_wr_en = 1'b0;
    i_circ_wr_en = 1'b0;
    i_agu_dec_model.issue(q);
  endtask

  function automatic agu_req_s mk(agu_class_e c, agu_mode_e m, logic [3:0] p,
                                  logic [15:0] mod);
    agu_req_s q;
    q = '0;
    q.iclass = c;
    q.mode = m;
    q.ptr = p;
    q.modifier = mod;
    q.ofs_reg = 4'h2;
    return q;
  endfunction

  task automatic op(input agu_row_s w);
    wput(w.p, w.base);
    wput(4'h2, 16'h0004);
    i_rd_idx = w.p;
    send(mk(w.c, w.m, w.p, w.mod));
    chkb(o_x.valid, w.v);
    chkb(o_x.err, w.e);
    if (w.v)
    begin
      chk(o_x.ea, w.ea);
      chk(o_op1, 16'h0004);
    end
    @(negedge i_core_clk);
    chk(o_rd_data, w.wb);
  endtask

  task automatic yop(input logic [15:0] ctrl, input logic [15:0] wb);
    creg(CR_CTRL, ctrl);
    wput(4'h8, 16'h0010);
    wput(4'hA, 16'h0206);
    r = mk(CL_MAC, AM_IND, 4'h8, 16'h0000);
    r.y_en = 1'b1;
    r.y_mode = AM_POST;
    r.y_ptr = 4'hA;
    r.y_modifier = 16'h0002;
    i_rd_idx = 4'hA;
    send(r);
    chkb(o_y.valid, 1'b1);
    chk(o_y.ea, 16'h0206);
    chkb(o_y.err, 1'b0);
    chkb(o_y.prog, 1'b0);
    @(negedge i_core_clk);
    chk(o_rd_data, wb);
  endtask

  // ============================================================
  // clock and watchdog
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  initial
  begin
    #200000;
    num_errors++;
    results();
  end

  // ============================================================
  // main sequence
  initial
  begin
    num_errors = 0;
    checked = 0;
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_wr_en = 1'b0;
    i_wr_idx = 4'h0;
    i_wr_data = 16'h0000;
    i_rd_idx = STACK_POINTER_REG;
    i_circ_wr_en = 1'b0;
    i_circ_wr_sel = CR_CTRL;
    i_circ_wr_data = 16'h0000;
    r = '0;
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk(o_circular_control, CTRL_RESET);
    i_resetn = 1'b1;
    @(negedge i_core_clk);
    chk(o_rd_data, SP_RESET);
    $display("reset test done");
    foreach (rows[k])
      op(rows[k]);
    $display("table test done");
    // direct, literal and destination cases
    r = mk(CL_FILE, AM_FILE, 4'h0, 16'h0000);
    r.file_addr = 13'h1ABC;
    send(r);
    chkb(o_dest.valid, 1'b1);
    chk(o_dest.addr, 16'h1ABC);
    chkb(o_dest.to_work, 1'b0);
    r.to_work = 1'b1;
    send(r);
    chkb(o_dest.to_work, 1'b1);
    chk({12'h000, o_dest.reg_idx}, {12'h000, DEFAULT_WORKING_REG});
    r = mk(CL_MOVE, AM_FILE, 4'h0, 16'h0000);
    r.literal = 16'hC000;
    r.prog = 1'b1;
    send(r);
    chk(o_x.ea, 16'hC000);
    chkb(o_x.prog, 1'b1);
    r = mk(CL_BRANCH, AM_DIRECT, 4'h0, 16'h0000);
    r.literal = 16'h8001;
    send(r);
    chk(o_literal, 16'h8001);
    chkb(o_x.valid, 1'b0);
    r.iclass = CL_DISABLE;
    r.literal = 16'hFFFF;
    send(r);
    chk(o_literal, 16'h3FFF);
    $display("literal test done");
    // request while the enable is low must leave everything frozen
    i_ce = 1'b0;
    send(mk(CL_MCU, AM_PRE, 4'h1, 16'h0002));
    chk(o_literal, 16'h3FFF);
    i_ce = 1'b1;
    @(negedge i_core_clk);
    chk(o_rd_data, 16'h0010);
    $display("enable test done");
    // X circular buffer of eight bytes
    creg(CR_X_START, 16'h0100);
    creg(CR_X_END, 16'h0107);
    creg(CR_CTRL, 16'h8001);
    chk(o_circular_control, 16'h8001);
    op('{CL_MCU, AM_POST, 4'h1, 16'h0002, 16'h0106, 1'b1, 1'b0, 16'h0106, 16'h0100});
    op('{CL_MCU, AM_PRE, 4'h1, 16'h0004, 16'h0106, 1'b1, 1'b0, 16'h0102, 16'h0102});
    op('{CL_MCU, AM_PRE, 4'h1, 16'hFFFE, 16'h0100, 1'b1, 1'b0, 16'h0106, 16'h0106});
    op('{CL_MOVE, AM_REGOFS, 4'h1, 16'h0000, 16'h0104, 1'b1, 1'b0, 16'h0100, 16'h0104});
    creg(CR_CTRL, 16'h800F);
    op('{CL_MCU, AM_POST, 4'h1, 16'h0002, 16'h0106, 1'b1, 1'b0, 16'h0106, 16'h0108});
    creg(CR_CTRL, 16'h0001);
    op('{CL_MCU, AM_POST, 4'h1, 16'h0002, 16'h0106, 1'b1, 1'b0, 16'h0106, 16'h0108});
    $display("x circular test done");
    // Y circular buffer, then its select field set to off
    creg(CR_Y_START, 16'h0200);
    creg(CR_Y_END, 16'h0207);
    yop(16'h40AF, 16'h0200);
    yop(16'h40FF, 16'h0208);
    r.y_ptr = 4'h8;
    send(r);
    chkb(o_y.valid, 1'b0);
    chkb(o_y.err, 1'b1);
    $display("y circular test done");
    // reset in mid-run
    @(negedge i_core_clk);
    i_resetn = 1'b0;
    i_rd_idx = 4'h1;
    @(negedge i_core_clk);
    chk(o_circular_control, CTRL_RESET);
    i_resetn = 1'b1;
    @(negedge i_core_clk);
    chk(o_rd_data, WORK_RESET);
    $display("second reset test done");
    results();
  end
endmodule
